//--- hw/cie_pkg.sv
// shared constants for the command / immediate / branch execution core
// assumes one clock domain and a byte-wide program memory with combinational read
package cie_pkg;
  // apb register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] LC_OFS = 12'h008;
  localparam logic [11:0] MASK_OFS = 12'h00C;
  // control register fields and reset value
  localparam int CTRL_RUN_POS = 0;
  localparam int CTRL_RESTART_POS = 1;
  localparam logic CTRL_RUN_RST = 1'b1;
  // opcode field, instruction word bits 15:12
  localparam logic [3:0] OP_CMD = 4'h1;
  localparam logic [3:0] OP_LI = 4'h2;
  localparam logic [3:0] OP_NI = 4'h3;
  localparam logic [3:0] OP_OI = 4'h4;
  localparam logic [3:0] OP_XI = 4'h5;
  localparam logic [3:0] OP_AI = 4'h6;
  localparam logic [3:0] OP_SI = 4'h7;
  localparam logic [3:0] OP_BR = 4'h8;
  // modifier positions (instruction bits 4..7 sit at word bits 11..8)
  localparam int MOD_DISCARD = 11;
  localparam int MOD_SKIP_POS = 10;
  localparam int MOD_SKIP_NZ = 9;
  localparam int MOD_SKIP_NC = 8;
  // command function positions (instruction bits 08..15 at word bits 7..0)
  localparam int CMD_SER_OUT = 7;
  localparam int CMD_LOAD_SW = 6;
  localparam int CMD_LOAD_MASK = 5;
  localparam int CMD_SER_IN = 4;
  localparam int CMD_SET_EN = 3;
  localparam int CMD_CLR_EN = 2;
  localparam int CMD_WAIT = 1;
  localparam int CMD_SHUT = 0;
  // branch conditions and addressing modes
  localparam logic [1:0] COND_ALWAYS = 2'h0;
  localparam logic [1:0] COND_NONZERO = 2'h1;
  localparam logic [1:0] COND_NO_CARRY = 2'h2;
  localparam logic [1:0] COND_POSITIVE = 2'h3;
  localparam logic [1:0] MODE_DIR_ZERO = 2'h0;
  localparam logic [1:0] MODE_DIR_CUR = 2'h1;
  localparam logic [1:0] MODE_IND_ZERO = 2'h2;
  localparam logic [1:0] MODE_IND_CUR = 2'h3;
  // addresses
  localparam logic [15:0] START_ADDR = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR = 16'h0002;
  localparam logic [15:0] STEP_NEXT = 16'h0002;
  localparam logic [15:0] STEP_SKIP = 16'h0004;
  // execution states
  typedef enum logic [2:0] {
    ST_FETCH_HI = 3'b000,
    ST_FETCH_LO = 3'b001,
    ST_EXEC = 3'b010,
    ST_IND_HI = 3'b011,
    ST_IND_LO = 3'b100,
    ST_WAIT = 3'b101,
    ST_HALT = 3'b110
  } exec_state_t;
endpackage : cie_pkg

//--- hw/imm_alu.sv
// immediate arithmetic and logical unit, purely combinational
// assumes the caller applies the update flags to accumulator and carry
`timescale 1ns/1ps
`default_nettype none
module imm_alu (
  input wire logic [3:0] op_in,       // immediate opcode
  input wire logic [3:0] mods_in,     // discard, positive, nonzero, no-carry
  input wire logic [7:0] acc_in,      // accumulator
  input wire logic [7:0] data_in,     // data field
  input wire logic carry_in,          // current carry
  output logic [7:0] result_out,      // operation result
  output logic carry_out,             // carry to keep
  output logic write_acc_out,         // accumulator may be written
  output logic skip_out               // skip next instruction
);
  logic [8:0] sum;
  logic arith;
  logic logical;
  logic carry_res;
  // result selection; subtract carry is the borrow
  always_comb
  begin
    sum = {1'b0, acc_in} + {1'b0, data_in};
    carry_res = carry_in;
    arith = 1'b0;
    result_out = data_in; // RQ12
    case (op_in)
      cie_pkg::OP_NI: result_out = acc_in & data_in; // RQ13
      cie_pkg::OP_OI: result_out = acc_in | data_in; // RQ13
      cie_pkg::OP_XI: result_out = acc_in ^ data_in; // RQ13
      cie_pkg::OP_AI:
      begin
        arith = 1'b1;
        carry_res = sum[8]; // RQ14
        result_out = sum[7:0];
      end
      cie_pkg::OP_SI:
      begin
        arith = 1'b1;
        sum = {1'b0, acc_in} - {1'b0, data_in};
        carry_res = sum[8]; // RQ15
        result_out = sum[7:0];
      end
      default: result_out = data_in;
    endcase
    logical = !arith;
    // discard keeps accumulator and carry but still tests
    write_acc_out = !mods_in[3]; // RQ11
    carry_out = (arith && !mods_in[3]) ? carry_res : carry_in; // RQ11
    skip_out = (mods_in[2] && !result_out[7]) // RQ10
      || (mods_in[1] && logical && (result_out != 8'h00))
      || (mods_in[0] && arith && !carry_res);
  end
endmodule : imm_alu
`default_nettype wire

//--- hw/branch_unit.sv
// branch condition test and direct target forming
// assumes the caller fetches the address word for the indirect modes
`timescale 1ns/1ps
`default_nettype none
module branch_unit (
  input wire logic [1:0] cond_in,     // condition field
  input wire logic [1:0] mode_in,     // addressing mode field
  input wire logic [7:0] acc_in,      // accumulator
  input wire logic carry_in,          // carry flag
  input wire logic [7:0] field_in,    // address field
  input wire logic [7:0] page_in,     // page of the address field byte
  output logic taken_out,             // condition holds
  output logic indirect_out,          // address word must be read
  output logic [15:0] target_out      // direct target or word pointer
);
  // condition decode
  always_comb
  begin
    case (cond_in)
      cie_pkg::COND_NONZERO: taken_out = (acc_in != 8'h00); // RQ17
      cie_pkg::COND_NO_CARRY: taken_out = !carry_in; // RQ17
      cie_pkg::COND_POSITIVE: taken_out = !acc_in[7]; // RQ17
      default: taken_out = 1'b1;
    endcase
  end
  // page zero for modes 00/10, otherwise the field byte's page; never indexed
  assign indirect_out = mode_in[1];
  assign target_out = (mode_in == cie_pkg::MODE_DIR_ZERO || mode_in == cie_pkg::MODE_IND_ZERO)
    ? {8'h00, field_in} : {page_in, field_in}; // RQ19 RQ20 RQ22
endmodule : branch_unit
`default_nettype wire

//--- hw/cie_core.sv
// execution core for command, immediate and branch instructions
// assumes byte memory with combinational read, synchronous panel and serial pins
// Functional notes
// RQ1 - bit 08 copies carry to serial output; bit 11 loads carry from serial input
// RQ2 - bit 09 loads accumulator from the eight panel data switches
// RQ3 - bit 10 copies accumulator into interrupt mask, accumulator kept
// RQ4 - bit 12 sets master interrupt enable, bit 13 clears it
// RQ5 - bit 14 enters wait; interrupt or panel restart clears the wait flip-flop
// RQ6 - interrupt during wait runs the next instruction before the interrupt
// RQ7 - bit 15 shuts down orderly; on power return execution starts at 0000
// RQ8 - software never combines enable set/clear, mask/switch load, serial in/out
// RQ9 - command functions run first, then skip conditions are tested
// RQ10 - immediate skips: result positive, result nonzero (logical), carry clear (arith)
// RQ11 - discard modifier keeps accumulator and carry but still tests skips
// RQ12 - load immediate puts data in accumulator unless discarded, carry kept
// RQ13 - and, or, xor immediate write accumulator unless discarded, carry kept
// RQ14 - add immediate writes sum and carry out unless discarded
// RQ15 - subtract immediate writes difference and borrow unless discarded
// RQ16 - current page is the page of the instruction's second byte
// RQ17 - branch condition: always, nonzero, carry clear, not negative
// RQ18 - false branch condition just steps to next instruction
// RQ19 - direct page-zero branch loads byte address, clears page
// RQ20 - direct current-page branch replaces byte address only
// RQ21 - indirect branch loads counter from word; bit 0 carry, bit 1 enable
// RQ22 - branch targets are never auto-indexed
// RQ23 - no interrupt before one instruction after a command completes
// RQ24 - command skips: carry clear or accumulator not negative
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cie_core #(
  parameter int ADDR_W = 16           // program address width
) (
  input wire logic sys_clk_in,        // core clock, 100 MHz
  input wire logic resetn_in,         // async reset, active low
  input wire logic [11:0] paddr_in,   // apb address
  input wire logic psel_in,           // apb select
  input wire logic penable_in,        // apb enable
  input wire logic pwrite_in,         // apb direction
  input wire logic [31:0] pwdata_in,  // apb write data
  output logic [31:0] prdata_out,     // apb read data
  output logic pready_out,            // apb ready
  output logic pslverr_out,           // apb error on unmapped address
  output logic [ADDR_W-1:0] mem_addr_out, // program memory byte address
  input wire logic [7:0] mem_rdata_in,    // program memory byte
  input wire logic [7:0] panel_switch_in, // panel data switches 08:15
  input wire logic panel_restart_in,  // panel restart pulse
  input wire logic power_restore_in,  // power returned after shutdown
  input wire logic serial_in,         // serial bit port input
  output logic serial_out,            // serial bit port output buffer
  input wire logic irq_in,            // masked interrupt request
  output logic int_ack_out,           // interrupt honored, one cycle
  output logic [7:0] int_mask_out,    // interrupt mask register
  output logic int_enable_out,        // master interrupt enable
  output logic wait_flag_out,         // wait flip-flop
  output logic shutdown_out           // orderly shutdown complete
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    cie_pkg::exec_state_t st;
    logic [ADDR_W-1:0] lc;
    logic [ADDR_W-1:0] addr;
    logic [15:0] ir;
    logic [7:0] page;
    logic [7:0] ptr_hi;
    logic [7:0] acc;
    logic carry;
    logic enable;
    logic [7:0] mask;
    logic wait_ff;
    logic ser_out;
    logic inhibit;
    logic run;
    logic int_ack;
    logic [31:0] prdata;
  } core_t;

  core_t s_reg;
  core_t s_next;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_write;
  logic alu_skip;
  logic br_taken;
  logic br_indirect;
  logic [15:0] br_target;
  logic is_cmd;
  logic is_imm;
  logic is_br;
  logic irq_ok;
  logic apb_setup;
  logic apb_wr;
  logic mapped;
  logic [7:0] cmd_acc;
  logic cmd_carry;
  logic [ADDR_W-1:0] next_lc;

  // address decode used only for the apb error response
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == cie_pkg::CTRL_OFS) || (a == cie_pkg::STATUS_OFS)
      || (a == cie_pkg::LC_OFS) || (a == cie_pkg::MASK_OFS);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // datapath helpers
  imm_alu u_alu (
    .op_in(s_reg.ir[15:12]),
    .mods_in(s_reg.ir[11:8]),
    .acc_in(s_reg.acc),
    .data_in(s_reg.ir[7:0]),
    .carry_in(s_reg.carry),
    .result_out(alu_result),
    .carry_out(alu_carry),
    .write_acc_out(alu_write),
    .skip_out(alu_skip)
  );

  branch_unit u_br (
    .cond_in(s_reg.ir[11:10]),
    .mode_in(s_reg.ir[9:8]),
    .acc_in(s_reg.acc),
    .carry_in(s_reg.carry),
    .field_in(s_reg.ir[7:0]),
    .page_in(s_reg.page),
    .taken_out(br_taken),
    .indirect_out(br_indirect),
    .target_out(br_target)
  );

  // instruction class decode
  assign is_cmd = (s_reg.ir[15:12] == cie_pkg::OP_CMD);
  assign is_imm = (s_reg.ir[15:12] >= cie_pkg::OP_LI) && (s_reg.ir[15:12] <= cie_pkg::OP_SI);
  assign is_br = (s_reg.ir[15:12] == cie_pkg::OP_BR);
  // the mask is applied outside; only the master enable gates here
  assign irq_ok = irq_in && s_reg.enable;
  assign apb_setup = psel_in && !penable_in;
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign mapped = is_mapped(paddr_in);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.int_ack = 1'b0;
    next_lc = s_reg.lc + ADDR_W'(cie_pkg::STEP_NEXT);
    // command results after switch and serial loads, used for skip tests
    cmd_acc = s_reg.ir[cie_pkg::CMD_LOAD_SW] ? panel_switch_in : s_reg.acc; // RQ2
    cmd_carry = s_reg.ir[cie_pkg::CMD_SER_IN] ? serial_in : s_reg.carry; // RQ1
    case (s_reg.st)
      cie_pkg::ST_FETCH_HI:
      begin
        if (!s_reg.run)
        begin
          s_next.addr = s_reg.lc;
        end
        else if (irq_ok && !s_reg.inhibit) // RQ23
        begin
          // vector to the interrupt entry, enable dropped
          s_next.int_ack = 1'b1;
          s_next.enable = 1'b0;
          s_next.lc = ADDR_W'(cie_pkg::IRQ_VECTOR);
          s_next.addr = ADDR_W'(cie_pkg::IRQ_VECTOR);
        end
        else
        begin
          s_next.ir[15:8] = mem_rdata_in;
          s_next.addr = s_reg.lc + ADDR_W'(1);
          s_next.st = cie_pkg::ST_FETCH_LO;
        end
      end
      cie_pkg::ST_FETCH_LO:
      begin
        s_next.ir[7:0] = mem_rdata_in;
        s_next.page = 8'(s_reg.addr >> 8); // RQ16
        s_next.st = cie_pkg::ST_EXEC;
      end
      cie_pkg::ST_EXEC:
      begin
        s_next.inhibit = 1'b0;
        s_next.st = cie_pkg::ST_FETCH_HI;
        if (is_cmd)
        begin
          // functions first, then skips on the updated values
          s_next.inhibit = 1'b1; // RQ23
          if (s_reg.ir[cie_pkg::CMD_SER_OUT])
          begin
            s_next.ser_out = s_reg.carry; // RQ1
          end
          s_next.carry = cmd_carry; // RQ1
          s_next.acc = cmd_acc; // RQ2
          if (s_reg.ir[cie_pkg::CMD_LOAD_MASK])
          begin
            s_next.mask = s_reg.acc; // RQ3
          end
          if (s_reg.ir[cie_pkg::CMD_SET_EN])
          begin
            s_next.enable = 1'b1; // RQ4
          end
          else if (s_reg.ir[cie_pkg::CMD_CLR_EN])
          begin
            s_next.enable = 1'b0; // RQ4
          end
          if ((s_reg.ir[cie_pkg::MOD_SKIP_NC] && !cmd_carry)
            || (s_reg.ir[cie_pkg::MOD_SKIP_POS] && !cmd_acc[7])) // RQ9 RQ24
          begin
            next_lc = s_reg.lc + ADDR_W'(cie_pkg::STEP_SKIP);
          end
          if (s_reg.ir[cie_pkg::CMD_SHUT])
          begin
            s_next.st = cie_pkg::ST_HALT; // RQ7
          end
          else if (s_reg.ir[cie_pkg::CMD_WAIT])
          begin
            s_next.wait_ff = 1'b1; // RQ5
            s_next.st = cie_pkg::ST_WAIT;
          end
        end
        else if (is_imm)
        begin
          if (alu_write)
          begin
            s_next.acc = alu_result; // RQ11 RQ12 RQ13
          end
          s_next.carry = alu_carry; // RQ14 RQ15
          if (alu_skip)
          begin
            next_lc = s_reg.lc + ADDR_W'(cie_pkg::STEP_SKIP); // RQ10
          end
        end
        else if (is_br && br_taken)
        begin
          if (br_indirect)
          begin
            // read the address word first; counter changes at the low byte
            s_next.st = cie_pkg::ST_IND_HI;
            s_next.addr = ADDR_W'(br_target); // RQ22
          end
          else
          begin
            next_lc = ADDR_W'(br_target); // RQ19 RQ20
          end
        end
        // a false branch just falls through to the next instruction
        if (s_next.st != cie_pkg::ST_IND_HI)
        begin
          s_next.lc = next_lc; // RQ18
          s_next.addr = next_lc;
        end
      end
      cie_pkg::ST_IND_HI:
      begin
        s_next.ptr_hi = mem_rdata_in;
        s_next.addr = s_reg.addr + ADDR_W'(1);
        s_next.st = cie_pkg::ST_IND_LO;
      end
      cie_pkg::ST_IND_LO:
      begin
        // top two word bits are flags, the rest is the location
        s_next.carry = s_reg.ptr_hi[7]; // RQ21
        s_next.enable = s_reg.ptr_hi[6]; // RQ21
        s_next.lc = ADDR_W'({2'b00, s_reg.ptr_hi[5:0], mem_rdata_in});
        s_next.addr = ADDR_W'({2'b00, s_reg.ptr_hi[5:0], mem_rdata_in});
        s_next.st = cie_pkg::ST_FETCH_HI;
      end
      cie_pkg::ST_WAIT:
      begin
        // interrupt wakes but the next instruction runs first
        if (irq_ok || panel_restart_in
          || (apb_wr && paddr_in == cie_pkg::CTRL_OFS && pwdata_in[cie_pkg::CTRL_RESTART_POS]))
        begin
          s_next.wait_ff = 1'b0; // RQ5
          s_next.inhibit = 1'b1; // RQ6
          s_next.st = cie_pkg::ST_FETCH_HI;
        end
      end
      cie_pkg::ST_HALT:
      begin
        if (power_restore_in)
        begin
          s_next.lc = ADDR_W'(cie_pkg::START_ADDR); // RQ7
          s_next.addr = ADDR_W'(cie_pkg::START_ADDR);
          s_next.inhibit = 1'b0;
          s_next.st = cie_pkg::ST_FETCH_HI;
        end
      end
      default: s_next.st = cie_pkg::ST_FETCH_HI;
    endcase
    // apb register writes and read data capture
    if (apb_wr && paddr_in == cie_pkg::CTRL_OFS)
    begin
      s_next.run = pwdata_in[cie_pkg::CTRL_RUN_POS];
    end
    if (apb_setup)
    begin
      if (paddr_in == cie_pkg::CTRL_OFS)
      begin
        s_next.prdata = {31'h00000000, s_reg.run};
      end
      else if (paddr_in == cie_pkg::STATUS_OFS)
      begin
        s_next.prdata = {13'h0000, s_reg.st, s_reg.acc, s_reg.ir[15:12], s_reg.inhibit,
          s_reg.wait_ff, s_reg.enable, s_reg.carry};
      end
      else if (paddr_in == cie_pkg::LC_OFS)
      begin
        s_next.prdata = 32'(s_reg.lc);
      end
      else if (paddr_in == cie_pkg::MASK_OFS)
      begin
        s_next.prdata = {24'h000000, s_reg.mask};
      end
      else
      begin
        s_next.prdata = 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; execution starts at 0000 after reset
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= '0;
      s_reg.run <= cie_pkg::CTRL_RUN_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs; read data is captured in the setup phase so no wait states
  assign prdata_out = s_reg.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign mem_addr_out = s_reg.addr;
  assign serial_out = s_reg.ser_out;
  assign int_ack_out = s_reg.int_ack;
  assign int_mask_out = s_reg.mask;
  assign int_enable_out = s_reg.enable;
  assign wait_flag_out = s_reg.wait_ff;
  assign shutdown_out = (s_reg.st == cie_pkg::ST_HALT);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic ex_cmd;
  assign ex_cmd = (s_reg.st == cie_pkg::ST_EXEC) && is_cmd;

  a_serial_out_copy: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ1
    ex_cmd && s_reg.ir[cie_pkg::CMD_SER_OUT] && !s_reg.ir[cie_pkg::CMD_SER_IN]
    |=> serial_out == $past(s_reg.carry) && s_reg.carry == $past(s_reg.carry))
    else $error("serial output does not hold carry");

  a_switch_load: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ2
    ex_cmd && s_reg.ir[cie_pkg::CMD_LOAD_SW] |=> s_reg.acc == $past(panel_switch_in))
    else $error("switch load missed");

  a_mask_load: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ3
    ex_cmd && s_reg.ir[cie_pkg::CMD_LOAD_MASK] && !s_reg.ir[cie_pkg::CMD_LOAD_SW]
    |=> int_mask_out == $past(s_reg.acc) && s_reg.acc == $past(s_reg.acc))
    else $error("mask load wrong");

  a_enable_ops: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ4
    ex_cmd && (s_reg.ir[cie_pkg::CMD_SET_EN] ^ s_reg.ir[cie_pkg::CMD_CLR_EN])
    |=> int_enable_out == $past(s_reg.ir[cie_pkg::CMD_SET_EN]))
    else $error("enable set or clear wrong");

  a_wait_entry: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ5
    ex_cmd && s_reg.ir[cie_pkg::CMD_WAIT] && !s_reg.ir[cie_pkg::CMD_SHUT]
    |=> wait_flag_out && mem_addr_out == s_reg.lc)
    else $error("wait not entered");

  a_power_restart: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ7
    shutdown_out && power_restore_in |=> mem_addr_out == '0 && !shutdown_out)
    else $error("restart not at zero");

  a_imm_discard: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ11
    s_reg.st == cie_pkg::ST_EXEC && is_imm && s_reg.ir[cie_pkg::MOD_DISCARD]
    |=> s_reg.acc == $past(s_reg.acc) && s_reg.carry == $past(s_reg.carry))
    else $error("discarded result stored");

  a_cmd_no_irq: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ23
    ex_cmd |-> ##1 !int_ack_out ##1 !int_ack_out ##1 !int_ack_out)
    else $error("interrupt right after command");

  a_branch_false: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ18
    s_reg.st == cie_pkg::ST_EXEC && is_br && !br_taken
    |=> s_reg.lc == $past(s_reg.lc) + ADDR_W'(2) && s_reg.acc == $past(s_reg.acc))
    else $error("false branch changed flow");

  a_branch_page0: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RQ19
    s_reg.st == cie_pkg::ST_EXEC && is_br && br_taken && s_reg.ir[9:8] == cie_pkg::MODE_DIR_ZERO
    |=> s_reg.lc == ADDR_W'($past(s_reg.ir[7:0])))
    else $error("page zero branch target wrong");
endmodule : cie_core
`default_nettype wire

//--- sim/prog_mem_model.sv
// program byte memory standing on the far side of the core
// assumes the bench fills mem directly; the read is combinational
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input wire logic [15:0] addr_in, // byte address
  output logic [7:0] rdata_out     // byte read
);
  logic [7:0] mem [0:255];
  // only page zero is backed; elsewhere a changing pattern, never a stale byte
  assign rdata_out = (addr_in[15:8] == 8'h00) ? mem[addr_in[7:0]] : (addr_in[7:0] ^ 8'hA5);
endmodule : prog_mem_model
`default_nettype wire

//--- sim/tb_cie_core.sv
// self-checking bench for the execution core
// assumes the memory model above and APB access to status
`timescale 1ns/1ps
`default_nettype none
module tb_cie_core;
  logic sys_clk_in, resetn_in, psel, penable, pwrite, restart, pwr, ser, irq;
  logic pready, pslverr, ser_o, ack, en, wt, shut, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lc;
  logic [15:0] maddr;
  logic [7:0] mdata, sw, mask;
  int num_errors = 0;
  int compares = 0;
  prog_mem_model prog_mem_model_i (.addr_in(maddr), .rdata_out(mdata));
  cie_core cie_core_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .mem_addr_out(maddr), .mem_rdata_in(mdata), .panel_switch_in(sw),
    .panel_restart_in(restart), .power_restore_in(pwr), .serial_in(ser), .serial_out(ser_o), .irq_in(irq),
    .int_ack_out(ack), .int_mask_out(mask), .int_enable_out(en), .wait_flag_out(wt), .shutdown_out(shut));
  ////////////////////////////////////////////////////////////////
  task automatic conclude(input bit hung);
    if (hung)
      num_errors++;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk_in);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      conclude(1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // program words land while the core sits in reset; bytes above 0x0F are left alone
  task automatic prog(input logic [15:0] p [8]);
    resetn_in <= 1'b0;
    for (int i = 0; i < 8; i++)
      {prog_mem_model_i.mem[2*i], prog_mem_model_i.mem[2*i+1]} = p[i];
    repeat (10) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (60) @(posedge sys_clk_in);
  endtask : prog
  // stop at the next fetch, then read counter and status
  task automatic halt();
    apb(1'b1, cie_pkg::CTRL_OFS, 32'h0000_0000);
    repeat (10) @(posedge sys_clk_in);
    apb(1'b0, cie_pkg::LC_OFS, 32'h0000_0000);
    lc = rd;
    apb(1'b0, cie_pkg::STATUS_OFS, 32'h0000_0000);
  endtask : halt
  ////////////////////////////////////////////////////////////////
  task automatic t_imm();
    prog('{16'h2080, 16'h6090, 16'h7820, 16'h32F0, 16'h4481, 16'h5681, 16'h20FF, 16'h800E});
    halt();
    check("imm acc", rd[15:8], 8'h91);
    check("imm carry", rd[0], 1'b1);
    check("imm lc", lc[15:0], 16'h000E);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
  endtask : t_imm
  task automatic t_cmd();
    prog('{16'h1048, 16'h10A4, 16'h1400, 16'h2000, 16'h1010, 16'h1080, 16'h800C, 16'h0000});
    halt();
    check("cmd acc", rd[15:8], 8'h5A);
    check("cmd carry", rd[0], 1'b1);
    check("cmd enable", en, 1'b0);
    check("cmd serial", ser_o, 1'b1);
    check("cmd mask", mask, 8'h5A);
    check("cmd lc", lc[15:0], 16'h000C);
  endtask : t_cmd
  task automatic t_branch();
    // self loop at 0x10 parks the counter on the indirect target
    prog_mem_model_i.mem[16] = 8'h80;
    prog_mem_model_i.mem[17] = 8'h10;
    prog('{16'h2000, 16'h8420, 16'h880A, 16'h20FF, 16'h20EE, 16'h8D0C, 16'h820E, 16'hC010});
    halt();
    check("br acc", rd[15:8], 8'h00);
    check("br carry", rd[0], 1'b1);
    check("br enable", rd[1], 1'b1);
    check("br lc", lc[15:0], 16'h0010);
  endtask : t_branch
  task automatic t_wait();
    int n;
    prog('{16'h1008, 16'h1002, 16'h2033, 16'h8006, 16'h0, 16'h0, 16'h0, 16'h0});
    check("wait flag", wt, 1'b1);
    irq <= 1'b1;
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge sys_clk_in);
    if (n == 50)
      conclude(1'b1);
    irq <= 1'b0;
    repeat (30) @(posedge sys_clk_in);
    apb(1'b0, cie_pkg::STATUS_OFS, 32'h0000_0000);
    check("wake acc", rd[15:8], 8'h33);
    restart <= 1'b1;
    @(posedge sys_clk_in);
    restart <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    check("restart wait", wt, 1'b0);
  endtask : t_wait
  task automatic t_shut();
    int n;
    prog('{16'h2077, 16'h1001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0});
    check("shutdown", shut, 1'b1);
    pwr <= 1'b1;
    for (n = 0; n < 20 && maddr !== cie_pkg::START_ADDR; n++)
      @(posedge sys_clk_in);
    check("restart addr", maddr, cie_pkg::START_ADDR);
    pwr <= 1'b0;
  endtask : t_shut
  ////////////////////////////////////////////////////////////////
  // clock, quiet inputs, then each scenario in turn
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    {resetn_in, psel, penable, pwrite, restart, pwr, irq} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sw = 8'h5A;
    ser = 1'b1;
    // whole memory cleared once; each program overwrites its first sixteen bytes, the branch test also bytes 16 and 17
    for (int i = 0; i < 256; i++)
      prog_mem_model_i.mem[i] = 8'h00;
    t_imm();
    t_cmd();
    t_branch();
    t_wait();
    t_shut();
    conclude(1'b0);
  end
endmodule : tb_cie_core
`default_nettype wire
